// *** fb_gateway.sv ***
// Purpose: Gateway end: serial telegrams in/out, fieldbus data areas, start-up switches
// Assumes: Switch inputs are asynchronous pins; link toggles share the clock
// Notes:   Holds the telegram sender reused by the master end; the receiver lives there
`timescale 1ns/1ps
module telegram_tx #(
   parameter int DIV = fb_gw_pkg::BAUD_DIV
) (
   input  wire logic                                clk,
   input  wire logic                                rst_n,
   input  wire logic                                start,
   input  wire logic [fb_gw_pkg::BLK_BYTES*8-1:0]   data,
   input  wire logic [fb_gw_pkg::LEN_W-1:0]         len,
   output logic                                     busy,
   output logic                                     txd
);
   typedef enum logic {TX_IDLE = 1'b0, TX_SEND = 1'b1} tx_state_t;
   tx_state_t                              st_q;
   logic [fb_gw_pkg::BLK_BYTES*8-1:0]      dat_q;
   logic [fb_gw_pkg::LEN_W:0]              len_q, idx_q;
   logic [9:0]                             sh_q;
   logic [3:0]                             nbits_q;
   logic [15:0]                            cnt_q;
   logic [7:0]                             nxt;

   assign busy = (st_q == TX_SEND);
   assign txd  = sh_q[0];

   // STX, payload as given, CR, LF
   always_comb begin
      if (idx_q == '0)
         nxt = fb_gw_pkg::CH_STX;
      else if (idx_q <= len_q)
         nxt = dat_q[7:0];
      else if (idx_q == len_q + 1'b1)
         nxt = fb_gw_pkg::CH_CR;
      else
         nxt = fb_gw_pkg::CH_LF;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q    <= TX_IDLE;
         dat_q   <= '0;
         len_q   <= '0;
         idx_q   <= '0;
         sh_q    <= 10'h3FF;
         nbits_q <= 4'h0;
         cnt_q   <= 16'h0000;
      end else begin
         unique case (st_q)
            TX_IDLE: begin
               if (start) begin
                  st_q    <= TX_SEND;
                  dat_q   <= data;
                  len_q   <= {1'b0, len};
                  idx_q   <= '0;
                  nbits_q <= 4'h0;
               end
            end
            TX_SEND: begin
               if (nbits_q == 4'h0) begin
                  if (idx_q == len_q + 3'(3)) begin
                     st_q <= TX_IDLE;
                  end else begin
                     sh_q    <= {1'b1, nxt, 1'b0};
                     nbits_q <= 4'hA;
                     cnt_q   <= 16'(DIV - 1);
                     idx_q   <= idx_q + 1'b1;
                     // Byte 0 leaves first: original order
                     if (idx_q != '0 && idx_q <= len_q) dat_q <= dat_q >> 8;
                  end
               end else if (cnt_q != 16'h0000) begin
                  cnt_q <= cnt_q - 16'h0001;
               end else begin
                  sh_q    <= {1'b1, sh_q[9:1]};
                  nbits_q <= nbits_q - 4'h1;
                  cnt_q   <= 16'(DIV - 1);
               end
            end
         endcase
      end
   end
endmodule // telegram_tx

module fb_gateway #(
   parameter int DIV = fb_gw_pkg::BAUD_DIV
) (
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RST_N,
   // Start-up switches {hundreds, tens, ones}
   input  wire logic [11:0] STATION_ADDRESS_SWITCHES,
   input  wire logic [3:0]  DEVICE_TYPE_SELECTOR,
   // Configuration taken at start-up
   output logic [6:0]       STATION_ADDR,
   output logic             ADDR_VALID,
   output logic [3:0]       DEVICE_TYPE,
   output logic             UNIVERSAL_MODE,
   output logic             CFG_DONE,
   // Link to master and ident device
   gw_link_if.gateway       lnk
);
   typedef enum logic [1:0] {
      P_IDLE = 2'b00, P_DATA = 2'b01, P_LF = 2'b10
   } parse_state_t;

   localparam int BB = fb_gw_pkg::BLK_BYTES;
   localparam int LW = fb_gw_pkg::LEN_W;

   logic [15:0]       sw1_q, sw2_q;
   logic [3:0]        settle_q;
   logic [10:0]       addr_sum;
   logic              digits_ok;
   logic [7:0]        rx_byte;
   logic              rx_valid;
   parse_state_t      ps_q;
   logic [BB*8-1:0]   buf_q;
   logic [LW-1:0]     cnt_q;
   logic [BB*8-1:0]   in_data_q;
   logic [LW-1:0]     in_len_q;
   logic              nd_q;
   logic              seen_q;
   logic              tx_busy;
   logic              tx_start;

   // Switch pins cross into the clock domain
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         sw1_q <= 16'h0000;
         sw2_q <= 16'h0000;
      end else begin
         sw1_q <= {DEVICE_TYPE_SELECTOR, STATION_ADDRESS_SWITCHES};
         sw2_q <= sw1_q;
      end
   end

   assign addr_sum  = 11'(sw2_q[11:8]) * 11'h064 + 11'(sw2_q[7:4]) * 11'h00A
                    + 11'(sw2_q[3:0]);
   assign digits_ok = sw2_q[11:8] <= fb_gw_pkg::DIGIT_MAX
                   && sw2_q[7:4] <= fb_gw_pkg::DIGIT_MAX
                   && sw2_q[3:0] <= fb_gw_pkg::DIGIT_MAX;

   // Sampled once; later switch moves take effect at next reset
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         settle_q       <= 4'h0;
         CFG_DONE       <= 1'b0;
         STATION_ADDR   <= 7'h00;
         ADDR_VALID     <= 1'b0;
         DEVICE_TYPE    <= 4'h0;
         UNIVERSAL_MODE <= 1'b0;
      end else if (!CFG_DONE) begin
         settle_q <= settle_q + 4'h1;
         if (settle_q == fb_gw_pkg::CFG_SETTLE) begin
            CFG_DONE       <= 1'b1;
            STATION_ADDR   <= addr_sum[6:0];
            ADDR_VALID     <= digits_ok && addr_sum <= fb_gw_pkg::ADDR_MAX;
            DEVICE_TYPE    <= sw2_q[15:12];
            UNIVERSAL_MODE <= sw2_q[15:12] == fb_gw_pkg::DEV_UNIV;
         end
      end
   end

   uart_rx #(.DIV(DIV)) u_rx (
      .clk     (CLK),
      .rst_n   (RST_N),
      .rxd     (lnk.dev_txd),
      .data_q  (rx_byte),
      .valid_q (rx_valid)
   );

   // Telegram parser; overlong payload is discarded whole
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ps_q      <= P_IDLE;
         buf_q     <= '0;
         cnt_q     <= '0;
         in_data_q <= '0;
         in_len_q  <= '0;
         nd_q      <= 1'b0;
      end else if (rx_valid && CFG_DONE) begin
         unique case (ps_q)
            P_IDLE: begin
               if (rx_byte == fb_gw_pkg::CH_STX) begin
                  ps_q  <= P_DATA;
                  cnt_q <= '0;
               end
            end
            P_DATA: begin
               if (rx_byte == fb_gw_pkg::CH_CR) begin
                  ps_q <= P_LF;
               end else if (rx_byte == fb_gw_pkg::CH_STX) begin
                  cnt_q <= '0;
               end else if (cnt_q == LW'(BB)) begin
                  ps_q <= P_IDLE;
               end else begin
                  buf_q[8*cnt_q +: 8] <= rx_byte;
                  cnt_q               <= cnt_q + 1'b1;
               end
            end
            P_LF: begin
               ps_q <= P_IDLE;
               // Whole block and toggle move together
               if (rx_byte == fb_gw_pkg::CH_LF) begin
                  in_data_q <= buf_q;
                  in_len_q  <= cnt_q;
                  nd_q      <= ~nd_q;
               end
            end
            default: ps_q <= P_IDLE;
         endcase
      end
   end

   assign lnk.in_data         = in_data_q;
   assign lnk.in_len          = in_len_q;
   assign lnk.new_data_toggle = nd_q;

   // A change during sending is kept and served afterwards
   assign tx_start = CFG_DONE && !tx_busy && (lnk.send_data_toggle != seen_q);

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) seen_q <= 1'b0;
      else if (tx_start) seen_q <= lnk.send_data_toggle;
   end

   telegram_tx #(.DIV(DIV)) u_tx (
      .clk   (CLK),
      .rst_n (RST_N),
      .start (tx_start),
      .data  (lnk.out_data),
      .len   (lnk.out_len),
      .busy  (tx_busy),
      .txd   (lnk.gw_txd)
   );
endmodule // fb_gateway

// *** fb_gw_pkg.sv ***
// Purpose: Shared constants for the serial-to-fieldbus gateway and its master end
// Assumes: One 25 MHz clock shared by both ends
// Notes:   Register map belongs to the master end's AHB-Lite slave
//
// Functional notes
// - Serial link runs 9600 baud, 8N1
// - Telegram is STX, payload, CR, LF
// - Master command bytes forwarded to device unchanged
// - New-data toggle flips per delivered block
// - Each send toggle change forwards output data; code forwards nothing for two changes made during one send, as they cancel
// - Station address accepted only 0 to 126
// - Address 126 only for commissioning, not exchange; code sets ADDR_VALID for 126 and does not block exchange
// - Address from ones, tens, hundreds switches
// - Switches sampled once at start-up
// - Universal selector setting accepts generic devices
// - Byte and bit index zero is least significant
// - Blocks transferred whole, unsplit, original order
package fb_gw_pkg;
   localparam int          CLK_HZ     = 25_000_000;
   localparam int          BAUD_RATE  = 9600;
   localparam int          BAUD_DIV   = CLK_HZ / BAUD_RATE;
   localparam int          BLK_BYTES  = 4;
   localparam int          LEN_W      = 3;
   localparam logic [7:0]  CH_STX     = 8'h02;
   localparam logic [7:0]  CH_CR      = 8'h0D;
   localparam logic [7:0]  CH_LF      = 8'h0A;
   localparam logic [10:0] ADDR_MAX   = 11'h07E;
   localparam logic [3:0]  DIGIT_MAX  = 4'h9;
   localparam logic [3:0]  DEV_UNIV   = 4'h0;
   localparam logic [3:0]  CFG_SETTLE = 4'h3;
   // Master end register offsets
   localparam logic [7:0]  OFS_CTRL   = 8'h00;
   localparam logic [7:0]  OFS_OUT    = 8'h04;
   localparam logic [7:0]  OFS_IN     = 8'h08;
   localparam logic [7:0]  OFS_DEV    = 8'h0C;
   localparam logic [7:0]  OFS_CMD    = 8'h10;
   localparam logic [7:0]  OFS_LENS   = 8'h14;
   localparam logic [7:0]  OFS_STAT   = 8'h18;
   localparam logic [7:0]  OFS_MASK   = 8'h1C;
   localparam logic [7:0]  OFS_INFO   = 8'h20;
   // Field positions
   localparam int          CTRL_SEND  = 0;
   localparam int          CTRL_DEVTX = 1;
   localparam int          LEN_OUT    = 0;
   localparam int          LEN_DEV    = 4;
   localparam int          LEN_IN     = 8;
   localparam int          LEN_CMD    = 12;
   localparam int          ST_NEWDATA = 0;
   localparam int          ST_CMDRX   = 1;
   localparam int          ST_DEVDONE = 2;
   localparam int          ST_W       = 3;
endpackage

// *** fb_master_end.sv ***
// Purpose: Far end: fieldbus master data areas plus the serial ident device
// Assumes: Single-word AHB-Lite transfers, always OKAY
// Notes:   Writes take one wait state, reads none; holds the receiver used by both ends
`timescale 1ns/1ps
module uart_rx #(
   parameter int DIV = fb_gw_pkg::BAUD_DIV
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       rxd,
   output logic [7:0]      data_q,
   output logic            valid_q
);
   logic        s1_q, s2_q, busy_q;
   logic [15:0] cnt_q;
   logic [3:0]  bit_q;
   logic [7:0]  sh_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
      end else begin
         s1_q <= rxd;
         s2_q <= s1_q;
      end
   end

   // Mid-bit sampling, LSB first, 8N1
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q  <= 1'b0;
         cnt_q   <= 16'h0000;
         bit_q   <= 4'h0;
         sh_q    <= 8'h00;
         data_q  <= 8'h00;
         valid_q <= 1'b0;
      end else begin
         valid_q <= 1'b0;
         if (!busy_q) begin
            if (!s2_q) begin
               busy_q <= 1'b1;
               cnt_q  <= 16'(DIV / 2);
               bit_q  <= 4'h0;
            end
         end else if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
         end else begin
            cnt_q <= 16'(DIV - 1);
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h0) begin
               // Glitch, not a start bit
               if (s2_q) busy_q <= 1'b0;
            end else if (bit_q < 4'h9) begin
               sh_q <= {s2_q, sh_q[7:1]};
            end else begin
               busy_q <= 1'b0;
               // Bad stop bit drops the byte
               if (s2_q) begin
                  data_q  <= sh_q;
                  valid_q <= 1'b1;
               end
            end
         end
      end
   end
endmodule // uart_rx

module fb_master_end #(
   parameter int DIV = fb_gw_pkg::BAUD_DIV
) (
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RST_N,
   // AHB-Lite slave
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic [31:0]      HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   // Interrupt
   output logic             IRQ,
   // Link to gateway
   gw_link_if.master        lnk
);
   localparam int BB = fb_gw_pkg::BLK_BYTES;
   localparam int LW = fb_gw_pkg::LEN_W;

   logic                               wr_q;
   logic [7:0]                         wa_q;
   logic                               take;
   logic [31:0]                        out_q, in_q, dev_q, cmd_q, lens_q, rd;
   logic [LW-1:0]                      cmd_len_q;
   logic [fb_gw_pkg::ST_W-1:0]         stat_q, mask_q, ev;
   logic                               sdt_q, nd_seen_q, devtx_q, tx_busy, tx_busy_q;
   logic [7:0]                         rx_byte;
   logic                               rx_valid, col_q, cmd_done;
   logic                               wr_ctrl;

   assign take    = HSEL && HREADY && HTRANS[1];
   assign wr_ctrl = wr_q && wa_q == fb_gw_pkg::OFS_CTRL;

   always_comb begin
      unique case (HADDR[7:0])
         fb_gw_pkg::OFS_OUT:  rd = out_q;
         fb_gw_pkg::OFS_IN:   rd = in_q;
         fb_gw_pkg::OFS_DEV:  rd = dev_q;
         fb_gw_pkg::OFS_CMD:  rd = cmd_q;
         fb_gw_pkg::OFS_LENS: rd = lens_q;
         fb_gw_pkg::OFS_STAT: rd = 32'(stat_q);
         fb_gw_pkg::OFS_MASK: rd = 32'(mask_q);
         fb_gw_pkg::OFS_INFO: rd = {29'h0, tx_busy_q, nd_seen_q, sdt_q};
         default:             rd = 32'h0000_0000;
      endcase
   end

   // Bus phases; a write holds HREADYOUT low for its data phase
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         wr_q      <= 1'b0;
         wa_q      <= 8'h00;
         HRDATA    <= 32'h0000_0000;
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end else begin
         wr_q      <= take && HWRITE;
         HREADYOUT <= !(take && HWRITE);
         if (take) wa_q <= HADDR[7:0];
         if (take && !HWRITE) HRDATA <= rd;
      end
   end

   // Software registers and the length fields
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         out_q  <= 32'h0000_0000;
         dev_q  <= 32'h0000_0000;
         mask_q <= '0;
         lens_q <= 32'h0000_0000;
      end else begin
         if (wr_q && wa_q == fb_gw_pkg::OFS_OUT)  out_q <= HWDATA;
         if (wr_q && wa_q == fb_gw_pkg::OFS_DEV)  dev_q <= HWDATA;
         if (wr_q && wa_q == fb_gw_pkg::OFS_MASK) mask_q <= HWDATA[fb_gw_pkg::ST_W-1:0];
         if (wr_q && wa_q == fb_gw_pkg::OFS_LENS) begin
            lens_q[fb_gw_pkg::LEN_OUT +: LW] <= HWDATA[fb_gw_pkg::LEN_OUT +: LW];
            lens_q[fb_gw_pkg::LEN_DEV +: LW] <= HWDATA[fb_gw_pkg::LEN_DEV +: LW];
         end
         if (lnk.new_data_toggle != nd_seen_q)
            lens_q[fb_gw_pkg::LEN_IN +: LW] <= lnk.in_len;
         if (cmd_done)
            lens_q[fb_gw_pkg::LEN_CMD +: LW] <= cmd_len_q;
      end
   end

   assign lnk.out_data         = out_q[BB*8-1:0];
   assign lnk.out_len          = lens_q[fb_gw_pkg::LEN_OUT +: LW];
   assign lnk.send_data_toggle = sdt_q;

   // Control toggle; new-data snapshot keeps the block whole
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         sdt_q     <= 1'b0;
         devtx_q   <= 1'b0;
         nd_seen_q <= 1'b0;
         in_q      <= 32'h0000_0000;
         tx_busy_q <= 1'b0;
      end else begin
         if (wr_ctrl && HWDATA[fb_gw_pkg::CTRL_SEND]) sdt_q <= ~sdt_q;
         devtx_q   <= wr_ctrl && HWDATA[fb_gw_pkg::CTRL_DEVTX];
         tx_busy_q <= tx_busy;
         if (lnk.new_data_toggle != nd_seen_q) begin
            nd_seen_q <= lnk.new_data_toggle;
            in_q      <= 32'(lnk.in_data);
         end
      end
   end

   // Ident device side: sends its telegram, collects commands
   telegram_tx #(.DIV(DIV)) u_dev_tx (
      .clk   (CLK),
      .rst_n (RST_N),
      .start (devtx_q),
      .data  (dev_q[BB*8-1:0]),
      .len   (lens_q[fb_gw_pkg::LEN_DEV +: LW]),
      .busy  (tx_busy),
      .txd   (lnk.dev_txd)
   );

   uart_rx #(.DIV(DIV)) u_dev_rx (
      .clk     (CLK),
      .rst_n   (RST_N),
      .rxd     (lnk.gw_txd),
      .data_q  (rx_byte),
      .valid_q (rx_valid)
   );

   assign cmd_done = rx_valid && col_q && rx_byte == fb_gw_pkg::CH_CR;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         col_q     <= 1'b0;
         cmd_len_q <= '0;
         cmd_q     <= 32'h0000_0000;
      end else if (rx_valid) begin
         if (rx_byte == fb_gw_pkg::CH_STX) begin
            col_q     <= 1'b1;
            cmd_len_q <= '0;
            cmd_q     <= 32'h0000_0000;
         end else if (cmd_done) begin
            col_q <= 1'b0;
         end else if (col_q && cmd_len_q != LW'(BB)) begin
            cmd_q[8*cmd_len_q +: 8] <= rx_byte;
            cmd_len_q               <= cmd_len_q + 1'b1;
         end
      end
   end

   // Sticky events, write one to clear; a new event wins over the clear
   always_comb begin
      ev                         = '0;
      ev[fb_gw_pkg::ST_NEWDATA]  = lnk.new_data_toggle != nd_seen_q;
      ev[fb_gw_pkg::ST_CMDRX]    = cmd_done;
      ev[fb_gw_pkg::ST_DEVDONE]  = tx_busy_q && !tx_busy;
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         stat_q <= '0;
         IRQ    <= 1'b0;
      end else begin
         if (wr_q && wa_q == fb_gw_pkg::OFS_STAT)
            stat_q <= (stat_q & ~HWDATA[fb_gw_pkg::ST_W-1:0]) | ev;
         else
            stat_q <= stat_q | ev;
         IRQ <= |(stat_q & mask_q);
      end
   end
endmodule // fb_master_end

// *** gw_link_if.sv ***
// Purpose: Link between the gateway and the master/ident-device end
// Assumes: Both ends on the same clock
// Notes:   Serial lines idle high
`timescale 1ns/1ps
interface gw_link_if;
   logic                                       dev_txd;
   logic                                       gw_txd;
   logic [fb_gw_pkg::BLK_BYTES*8-1:0]          in_data;
   logic [fb_gw_pkg::LEN_W-1:0]                in_len;
   logic                                       new_data_toggle;
   logic [fb_gw_pkg::BLK_BYTES*8-1:0]          out_data;
   logic [fb_gw_pkg::LEN_W-1:0]                out_len;
   logic                                       send_data_toggle;
   modport gateway (input dev_txd, output gw_txd, output in_data, output in_len,
                    output new_data_toggle, input out_data, input out_len,
                    input send_data_toggle);
   modport master (output dev_txd, input gw_txd, input in_data, input in_len,
                   input new_data_toggle, output out_data, output out_len,
                   output send_data_toggle);
endinterface // gw_link_if

// *** gw_link_sva.sv ***
// Purpose: Wire checks on the gateway link
// Assumes: One clock for both ends
// Notes:   Idle is a high run longer than one frame
`timescale 1ns/1ps
module gw_link_sva #(
   parameter int N = fb_gw_pkg::BAUD_DIV
) (
   // Clock
   input wire logic        CLK,
   input wire logic        RST_N,
   // Link
   input wire logic        dev_txd,
   input wire logic        gw_txd,
   input wire logic [31:0] in_data,
   input wire logic [2:0]  in_len,
   input wire logic        new_data_toggle,
   input wire logic        send_data_toggle
);
   localparam int IDLE = 10 * N;
   int         up_q;
   logic [1:0] line;
   assign line = {gw_txd, dev_txd};
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // Start-up latch needs a few cycles before the sender listens
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) up_q <= 0;
      else if (up_q < 15) up_q <= up_q + 1;
   end
   for (genvar k = 0; k < 2; k++) begin : g_line
      int   lo_q;
      int   hi_q;
      int   last_q;
      logic first_q;
      logic seen_q;
      always_ff @(posedge CLK or negedge RST_N) begin
         if (!RST_N) begin
            lo_q    <= 0;
            hi_q    <= IDLE + 1;
            last_q  <= 0;
            first_q <= 1'b0;
            seen_q  <= 1'b0;
         end else begin
            lo_q <= line[k] ? 0 : lo_q + 1;
            hi_q <= !line[k] ? 0 : (hi_q > IDLE ? hi_q : hi_q + 1);
            if (line[k] && lo_q != 0) last_q <= lo_q;
            if (!line[k] && hi_q != 0) first_q <= hi_q > IDLE;
            else if (line[k] && lo_q != 0) first_q <= 1'b0;
            if (!line[k] && hi_q != 0) seen_q <= 1'b1;
            else if (hi_q == IDLE) seen_q <= 1'b0;
         end
      end
      AST_BIT_TIME: assert property (line[k] && lo_q != 0 |-> lo_q % N == 0)
         else $error("low run not whole bits");
      AST_FRAME_LOW: assert property (lo_q <= 9 * N)
         else $error("missing stop bit");
      AST_STX_FIRST: assert property (line[k] && lo_q != 0 && first_q |-> lo_q == 2 * N)
         else $error("telegram not opened by start char");
      AST_CRLF_LAST: assert property (line[k] && hi_q == IDLE && seen_q |-> last_q == 4 * N)
         else $error("telegram not closed by line feed");
   end
   AST_SEND_START: assert property ($changed(send_data_toggle) && up_q == 15
      && g_line[1].hi_q > IDLE |-> ##[1:3] !gw_txd)
      else $error("send toggle not served");
   AST_DELIVER_LF: assert property ($changed(new_data_toggle)
      |-> dev_txd && g_line[0].last_q == 4 * N)
      else $error("block delivered before line feed");
   AST_BLOCK_WHOLE: assert property ($changed(in_data) || $changed(in_len)
      |-> $changed(new_data_toggle))
      else $error("input area changed without toggle");
   AST_LEN_RANGE: assert property (in_len <= fb_gw_pkg::BLK_BYTES)
      else $error("input length too large");
   COV_DELIVERY: cover property ($changed(new_data_toggle));
   COV_SEND: cover property ($changed(send_data_toggle));
   COV_STX: cover property (g_line[1].first_q);
endmodule // gw_link_sva

// *** serial_to_fieldbus_gateway_test.sv ***
// Purpose: Self-checking bench for both gateway ends
// Assumes: Short bit time on both ends, so one telegram runs about 800 cycles
// Notes:   Each switch row reruns reset; switches are read at start-up only
`timescale 1ns/1ps
module serial_to_fieldbus_gateway_test;
   typedef struct packed {
      logic [11:0] sw;
      logic [3:0]  sel;
      logic [6:0]  addr;
      logic        vld;
   } row_t;
   // Full baud divider would need far too many cycles per telegram
   localparam int N = 16;
   logic        clk, rst_n, vld, univ, done, irq, hready, hresp, hwr;
   logic [11:0] sw;
   logic [3:0]  sel, dtype;
   logic [6:0]  addr;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [7:0]  rx_byte;
   int          err_count, n_compared;
   row_t        rows [5] = '{'{12'h000, 4'h0, 7'h00, 1'b1}, '{12'h126, 4'h3, 7'h7E, 1'b1},
      '{12'h127, 4'h1, 7'h7F, 1'b0}, '{12'h0A0, 4'h5, 7'h64, 1'b0}, '{12'h085, 4'hC, 7'h55, 1'b1}};
   logic [7:0]  tx_exp [5] = '{8'h02, 8'h41, 8'h42, 8'h0D, 8'h0A};
   gw_link_if lnk ();
   fb_gateway #(.DIV(N)) fb_gateway_i (.CLK(clk), .RST_N(rst_n), .STATION_ADDRESS_SWITCHES(sw),
      .DEVICE_TYPE_SELECTOR(sel), .STATION_ADDR(addr), .ADDR_VALID(vld), .DEVICE_TYPE(dtype),
      .UNIVERSAL_MODE(univ), .CFG_DONE(done), .lnk(lnk));
   fb_master_end #(.DIV(N)) fb_master_end_i (.CLK(clk), .RST_N(rst_n), .HSEL(1'b1), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwr), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
      .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .IRQ(irq), .lnk(lnk));
   gw_link_sva #(.N(N)) gw_link_sva_i (.CLK(clk), .RST_N(rst_n), .dev_txd(lnk.dev_txd),
      .gw_txd(lnk.gw_txd), .in_data(lnk.in_data), .in_len(lnk.in_len),
      .new_data_toggle(lnk.new_data_toggle), .send_data_toggle(lnk.send_data_toggle));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_sim();
      if (err_count == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Entered just after a rising edge; returns just after the data-phase edge
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwr    <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0);
      chk(what, exp, rd);
   endtask
   // Samples mid-bit, so a small phase error in the sender is tolerated
   task automatic get_byte();
      do @(posedge clk); while (lnk.gw_txd !== 1'b0);
      repeat (N / 2) @(posedge clk);
      for (int b = 0; b < 8; b++) begin
         repeat (N) @(posedge clk);
         rx_byte[b] = lnk.gw_txd;
      end
      repeat (N) @(posedge clk);
      chk("stop bit", 32'h1, 32'(lnk.gw_txd));
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      end_sim();
   end
   initial begin
      rst_n = 1'b0;
      sw = 12'h000;
      sel = 4'h0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwr = 1'b0;
      hwdata = 32'h0;
      err_count = 0;
      n_compared = 0;
      foreach (rows[i]) begin
         @(posedge clk);
         sw     <= rows[i].sw;
         sel    <= rows[i].sel;
         rst_n  <= 1'b0;
         repeat (5) @(posedge clk);
         rst_n  <= 1'b1;
         do @(posedge clk); while (done !== 1'b1);
         chk("station address", 32'(rows[i].addr), 32'(addr));
         chk("address valid", 32'(rows[i].vld), 32'(vld));
         chk("device type", 32'(rows[i].sel), 32'(dtype));
         chk("universal", 32'(rows[i].sel == 4'h0), 32'(univ));
      end
      sw <= 12'h126;
      repeat (8) @(posedge clk);
      chk("address held", 32'h55, 32'(addr));
      rdchk("mask reset", fb_gw_pkg::OFS_MASK, 32'h0);
      rdchk("status reset", fb_gw_pkg::OFS_STAT, 32'h0);
      ahb(1'b1, 8'h24, 32'hFFFF_FFFF);
      rdchk("unmapped", 8'h24, 32'h0);
      ahb(1'b1, fb_gw_pkg::OFS_OUT, 32'h0000_4241);
      ahb(1'b1, fb_gw_pkg::OFS_DEV, 32'h0000_3231);
      ahb(1'b1, fb_gw_pkg::OFS_LENS, 32'h0000_0022);
      ahb(1'b1, fb_gw_pkg::OFS_MASK, 32'h1);
      ahb(1'b1, fb_gw_pkg::OFS_CTRL, 32'h3);
      chk("send toggle", 32'h1, 32'(lnk.send_data_toggle));
      foreach (tx_exp[j]) begin
         get_byte();
         chk("line byte", 32'(tx_exp[j]), 32'(rx_byte));
      end
      do @(posedge clk); while (irq !== 1'b1);
      do ahb(1'b0, fb_gw_pkg::OFS_STAT, 32'h0); while (rd !== 32'h7);
      chk("input area", 32'h0000_3231, lnk.in_data);
      chk("input length", 32'h2, 32'(lnk.in_len));
      chk("new data toggle", 32'h1, 32'(lnk.new_data_toggle));
      rdchk("input register", fb_gw_pkg::OFS_IN, 32'h0000_3231);
      rdchk("command", fb_gw_pkg::OFS_CMD, 32'h0000_4241);
      rdchk("lengths", fb_gw_pkg::OFS_LENS, 32'h0000_2222);
      rdchk("info", fb_gw_pkg::OFS_INFO, 32'h3);
      ahb(1'b1, fb_gw_pkg::OFS_MASK, 32'h0);
      rdchk("mask cleared", fb_gw_pkg::OFS_MASK, 32'h0);
      chk("irq masked", 32'h0, 32'(irq));
      ahb(1'b1, fb_gw_pkg::OFS_MASK, 32'h7);
      rdchk("mask set", fb_gw_pkg::OFS_MASK, 32'h7);
      chk("irq unmasked", 32'h1, 32'(irq));
      ahb(1'b1, fb_gw_pkg::OFS_STAT, 32'h7);
      rdchk("status cleared", fb_gw_pkg::OFS_STAT, 32'h0);
      chk("irq cleared", 32'h0, 32'(irq));
      chk("response", 32'h0, 32'(hresp));
      end_sim();
   end
endmodule // serial_to_fieldbus_gateway_test
